/* src/cfte_pkg.sv */
// shared constants, types and decode for the fine-edge timing generator
package cfte_pkg;

    // fine position grid within one master clock period
    localparam int unsigned POS_COUNT = 48;
    localparam logic [5:0]  POS_LAST  = 6'h2f;
    localparam logic [3:0]  OFS_LIMIT = 4'hc;   // offsets 12..15 are holes
    localparam logic [5:0]  QUAD_STEP = 6'h0c;

    // serial register addresses
    localparam logic [7:0] ADDR_OPR_LO   = 8'h00;
    localparam logic [7:0] ADDR_OPR_HI   = 8'h01;
    localparam logic [7:0] ADDR_STEER    = 8'h06;
    localparam logic [7:0] ADDR_HA_POL   = 8'he5;
    localparam logic [7:0] ADDR_HA_RISE  = 8'he6;
    localparam logic [7:0] ADDR_HA_FALL  = 8'he7;
    localparam logic [7:0] ADDR_HA_DRV   = 8'he8;
    localparam logic [7:0] ADDR_HAI_DRV  = 8'he9;
    localparam logic [7:0] ADDR_HB_DRV   = 8'hea;
    localparam logic [7:0] ADDR_HBI_DRV  = 8'heb;
    localparam logic [7:0] ADDR_RG_POL   = 8'hec;
    localparam logic [7:0] ADDR_RG_RISE  = 8'hed;
    localparam logic [7:0] ADDR_RG_FALL  = 8'hee;
    localparam logic [7:0] ADDR_RG_DRV   = 8'hef;
    localparam logic [7:0] ADDR_REF_LOC  = 8'hf0;
    localparam logic [7:0] ADDR_SIG_LOC  = 8'hf1;
    localparam logic [7:0] ADDR_HB_POL   = 8'hf2;
    localparam logic [7:0] ADDR_HB_RISE  = 8'hf3;
    localparam logic [7:0] ADDR_HB_FALL  = 8'hf4;
    localparam logic [7:0] ADDR_STATUS   = 8'hf8;

    // operating_control fields
    localparam int unsigned OPR_PWR_LSB   = 0;
    localparam int unsigned OPR_BLACK_BIT = 2;
    localparam int unsigned OPR_HI_LSB    = 6;
    // color_steering_control fields
    localparam int unsigned STEER_GAIN_BIT  = 3;
    localparam int unsigned STEER_LATCH_BIT = 4;
    localparam int unsigned STEER_FLOAT_BIT = 5;

    // reset values
    localparam logic [7:0] RST_OPR      = 8'h00;
    localparam logic [5:0] RST_STEER    = 6'h00;
    localparam logic [5:0] RST_H_RISE   = 6'h00;
    localparam logic [5:0] RST_H_FALL   = 6'h20;
    localparam logic [2:0] RST_H_DRV    = 3'h3;
    localparam logic [5:0] RST_RG_RISE  = 6'h00;
    localparam logic [5:0] RST_RG_FALL  = 6'h10;
    localparam logic [2:0] RST_RG_DRV   = 3'h2;
    localparam logic [5:0] RST_REF_LOC  = 6'h24;
    localparam logic [5:0] RST_SIG_LOC  = 6'h00;
    localparam logic [2:0] DRV_OFF      = 3'h0;
    localparam logic [5:0] DOUT_LATCH_POS = 6'h00;

    typedef enum logic [1:0] {
        CFTE_PWR_FULL     = 2'b00,
        CFTE_PWR_FAST     = 2'b01,
        CFTE_PWR_STANDBY  = 2'b10,
        CFTE_PWR_SHUTDOWN = 2'b11
    } cfte_power_t;

    typedef enum logic [2:0] {
        CFTE_STEER_OFF      = 3'b000,
        CFTE_STEER_MOS_SEP  = 3'b001,
        CFTE_STEER_VD_MOS   = 3'b010,
        CFTE_STEER_MOS_REP  = 3'b011,
        CFTE_STEER_THREE    = 3'b100,
        CFTE_STEER_THREE_2  = 3'b101,
        CFTE_STEER_FOUR     = 3'b110,
        CFTE_STEER_FOUR_2   = 3'b111
    } cfte_steer_t;

    typedef struct packed {
        logic       pol;
        logic [5:0] rise;
        logic [5:0] fall;
        logic [2:0] drv;
    } cfte_edge_cfg_t;

    typedef struct packed {
        logic       valid;
        logic [5:0] pos;
    } cfte_loc_t;

    // location code: quadrant*12 + offset, offsets 12..15 invalid
    function automatic cfte_loc_t cfte_loc_decode(input logic [5:0] code);
        cfte_loc_t r;
        r.valid = (code[3:0] < OFS_LIMIT);
        r.pos   = 6'(6'(code[5:4]) * QUAD_STEP) + 6'(code[3:0]);
        return r;
    endfunction

endpackage

/* src/cfte_pos_counter.sv */
// master clock synchroniser and 48-step fine position counter
`timescale 1ns/1ps
`default_nettype none
module cfte_pos_counter (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       master_clock_in,
    output logic [5:0]      pos,
    output logic            period_start
);
    import cfte_pkg::*;

    logic sync_1;
    logic sync_2;
    logic sync_3;
    logic ref_level;

    // three stages; the first is only read by the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync_1 <= 1'b0;
            sync_2 <= 1'b0;
            sync_3 <= 1'b0;
        end else begin
            sync_1 <= master_clock_in;
            sync_2 <= sync_1;
            sync_3 <= sync_2;
        end
    end

    // accept a level only once two stages agree, filtering single glitches
    assign period_start = (sync_2 == sync_3) && sync_2 && !ref_level;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_level <= 1'b0;
        end else if (sync_2 == sync_3) begin
            ref_level <= sync_2;
        end
    end

    // restart at 0 on each reference rise, else step and wrap after 47
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos <= 6'h00;
        end else if (period_start) begin
            pos <= 6'h00;
        end else if (pos == POS_LAST) begin
            pos <= 6'h00;
        end else begin
            pos <= pos + 6'h01;
        end
    end

    a_pos_range : assert property (@(posedge clk) disable iff (!rst_n)
        pos <= POS_LAST) else $error("fine position left 0..47");
    a_pos_wrap : assert property (@(posedge clk) disable iff (!rst_n)
        (pos == POS_LAST) |=> (pos == 6'h00)) else $error("position did not wrap");
    a_pos_align : assert property (@(posedge clk) disable iff (!rst_n)
        period_start |=> (pos == 6'h00)) else $error("position not restarted");

endmodule
`default_nettype wire

/* src/cfte_edge_wave.sv */
// one programmable-edge waveform with polarity and drive-off control
`timescale 1ns/1ps
`default_nettype none
module cfte_edge_wave (
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic [5:0]               pos,
    input  wire cfte_pkg::cfte_edge_cfg_t cfg,
    output logic                          wave,
    output logic                          oe_n
);
    import cfte_pkg::*;

    cfte_loc_t rise_loc;
    cfte_loc_t fall_loc;
    logic      level;
    logic      next_level;

    assign rise_loc = cfte_loc_decode(cfg.rise);
    assign fall_loc = cfte_loc_decode(cfg.fall);

    // rise wins when both edges share one position; holes never fire
    always_comb begin
        next_level = level;
        if (rise_loc.valid && pos == rise_loc.pos) begin
            next_level = 1'b1;
        end else if (fall_loc.valid && pos == fall_loc.pos) begin
            next_level = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level <= 1'b0;
        end else begin
            level <= next_level;
        end
    end

    // polarity applied at the output flop so the pin is glitch free
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wave <= 1'b0;
            oe_n <= 1'b1;
        end else begin
            wave <= next_level ^ cfg.pol;
            oe_n <= (cfg.drv == DRV_OFF);
        end
    end

    a_edge_rise : assert property (@(posedge clk) disable iff (!rst_n)
        (rise_loc.valid && pos == rise_loc.pos) |=> (wave != $past(cfg.pol)))
        else $error("rising edge not placed");
    a_edge_fall : assert property (@(posedge clk) disable iff (!rst_n)
        (fall_loc.valid && pos == fall_loc.pos && !(rise_loc.valid && rise_loc.pos == pos))
        |=> (wave == $past(cfg.pol))) else $error("falling edge not placed");
    a_drive_off : assert property (@(posedge clk) disable iff (!rst_n)
        (cfg.drv == DRV_OFF) |=> oe_n) else $error("off drive still enabled");

endmodule
`default_nettype wire

/* src/cfte_timing_gen.sv */
// fine-edge timing generator top: serial registers, edges, strobes, AFE control
//
// Function
// - master period split into 48 positions
// - reset gate: own rise, fall, polarity
// - hclk_a, hclk_b: own rise, fall, polarity
// - inverse clocks always follow their mates
// - code is quadrant*12 plus offset 0..11
// - polarity bit 1 inverts programmed waveform
// - rise code sets edge or sample spot
// - fall code sets falling edge
// - three-bit drive level held per output
// - drive level zero floats the output
// - operating control split over two addresses
// - power state field picks four modes
// - black loop off bit disables clamping
// - steering mode register, eight colour modes
// - gain steering enable bit
// - output latch versus transparent select
// - converter outputs driven or floated
`timescale 1ns/1ps
`default_nettype none
module cfte_timing_gen (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  master_clock_in,
    input  wire logic                  wr_en,
    input  wire logic [7:0]            wr_addr,
    input  wire logic [5:0]            wr_data,
    input  wire logic [7:0]            rd_addr,
    output logic [7:0]                 rd_data,
    output logic                       reset_gate_out,
    output logic                       reset_gate_oe_n,
    output logic                       hclk_a,
    output logic                       hclk_a_oe_n,
    output logic                       hclk_a_inv,
    output logic                       hclk_a_inv_oe_n,
    output logic                       hclk_b,
    output logic                       hclk_b_oe_n,
    output logic                       hclk_b_inv,
    output logic                       hclk_b_inv_oe_n,
    output logic [2:0]                 reset_gate_drive,
    output logic [2:0]                 hclk_a_drive,
    output logic [2:0]                 hclk_a_inv_drive,
    output logic [2:0]                 hclk_b_drive,
    output logic [2:0]                 hclk_b_inv_drive,
    output logic                       reference_sample_strobe,
    output logic                       signal_sample_strobe,
    output cfte_pkg::cfte_power_t      power_state_sel,
    output logic                       black_clamp_en,
    output logic [4:0]                 test_bits,
    output cfte_pkg::cfte_steer_t      color_steer_mode,
    output logic                       pixel_gain_steer_en,
    input  wire logic [9:0]            adc_data_in,
    output logic [9:0]                 adc_data_out,
    output logic                       adc_data_oe_n
);
    import cfte_pkg::*;

    logic [7:0]     operating_control;
    logic [5:0]     color_steering_control;
    cfte_edge_cfg_t rg_cfg;
    cfte_edge_cfg_t ha_cfg;
    cfte_edge_cfg_t hb_cfg;
    logic [2:0]     ha_inv_drv;
    logic [2:0]     hb_inv_drv;
    logic [5:0]     ref_loc_code;
    logic [5:0]     sig_loc_code;
    logic [5:0]     pos;
    logic           period_start;
    logic           ha_wave;
    logic           hb_wave;
    logic           ha_oe_n_w;
    logic           hb_oe_n_w;
    cfte_loc_t      ref_loc;
    cfte_loc_t      sig_loc;
    logic [7:0]     next_rd_data;
    logic           wr_opr_lo;
    logic           wr_opr_hi;

    assign wr_opr_lo = wr_en && (wr_addr == ADDR_OPR_LO);
    assign wr_opr_hi = wr_en && (wr_addr == ADDR_OPR_HI);

    // operating control loads low six and high two bits separately
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            operating_control <= RST_OPR;
        end else if (wr_opr_lo) begin
            operating_control[5:0] <= wr_data;
        end else if (wr_opr_hi) begin
            operating_control[7:OPR_HI_LSB] <= wr_data[1:0];
        end
    end

    // colour steering control, one address, six bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            color_steering_control <= RST_STEER;
        end else if (wr_en && wr_addr == ADDR_STEER) begin
            color_steering_control <= wr_data;
        end
    end

    // edge configuration for the reset gate and both horizontal clocks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rg_cfg     <= '{pol: 1'b0, rise: RST_RG_RISE, fall: RST_RG_FALL, drv: RST_RG_DRV};
            ha_cfg     <= '{pol: 1'b0, rise: RST_H_RISE, fall: RST_H_FALL, drv: RST_H_DRV};
            hb_cfg     <= '{pol: 1'b0, rise: RST_H_RISE, fall: RST_H_FALL, drv: RST_H_DRV};
            ha_inv_drv <= RST_H_DRV;
            hb_inv_drv <= RST_H_DRV;
        end else if (wr_en) begin
            unique case (wr_addr)
                ADDR_RG_POL:  rg_cfg.pol  <= wr_data[0];
                ADDR_RG_RISE: rg_cfg.rise <= wr_data;
                ADDR_RG_FALL: rg_cfg.fall <= wr_data;
                ADDR_RG_DRV:  rg_cfg.drv  <= wr_data[2:0];
                ADDR_HA_POL:  ha_cfg.pol  <= wr_data[0];
                ADDR_HA_RISE: ha_cfg.rise <= wr_data;
                ADDR_HA_FALL: ha_cfg.fall <= wr_data;
                ADDR_HA_DRV:  ha_cfg.drv  <= wr_data[2:0];
                ADDR_HAI_DRV: ha_inv_drv  <= wr_data[2:0];
                ADDR_HB_POL:  hb_cfg.pol  <= wr_data[0];
                ADDR_HB_RISE: hb_cfg.rise <= wr_data;
                ADDR_HB_FALL: hb_cfg.fall <= wr_data;
                ADDR_HB_DRV:  hb_cfg.drv  <= wr_data[2:0];
                ADDR_HBI_DRV: hb_inv_drv  <= wr_data[2:0];
                default: ;
            endcase
        end
    end

    // sample strobe locations
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ref_loc_code <= RST_REF_LOC;
            sig_loc_code <= RST_SIG_LOC;
        end else if (wr_en && wr_addr == ADDR_REF_LOC) begin
            ref_loc_code <= wr_data;
        end else if (wr_en && wr_addr == ADDR_SIG_LOC) begin
            sig_loc_code <= wr_data;
        end
    end

    // position grid locked to the master clock reference
    cfte_pos_counter u_pos (
        .clk             (clk),
        .rst_n           (rst_n),
        .master_clock_in (master_clock_in),
        .pos             (pos),
        .period_start    (period_start)
    );

    cfte_edge_wave u_rg (
        .clk   (clk),
        .rst_n (rst_n),
        .pos   (pos),
        .cfg   (rg_cfg),
        .wave  (reset_gate_out),
        .oe_n  (reset_gate_oe_n)
    );

    cfte_edge_wave u_ha (
        .clk   (clk),
        .rst_n (rst_n),
        .pos   (pos),
        .cfg   (ha_cfg),
        .wave  (ha_wave),
        .oe_n  (ha_oe_n_w)
    );

    cfte_edge_wave u_hb (
        .clk   (clk),
        .rst_n (rst_n),
        .pos   (pos),
        .cfg   (hb_cfg),
        .wave  (hb_wave),
        .oe_n  (hb_oe_n_w)
    );

    // inverse clocks come from the same flops, so no skew between pairs
    assign hclk_a     = ha_wave;
    assign hclk_b     = hb_wave;
    assign hclk_a_inv = ~ha_wave;
    assign hclk_b_inv = ~hb_wave;
    assign hclk_a_oe_n = ha_oe_n_w;
    assign hclk_b_oe_n = hb_oe_n_w;

    // inverse outputs float on their own zero drive level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hclk_a_inv_oe_n <= 1'b1;
            hclk_b_inv_oe_n <= 1'b1;
        end else begin
            hclk_a_inv_oe_n <= (ha_inv_drv == DRV_OFF);
            hclk_b_inv_oe_n <= (hb_inv_drv == DRV_OFF);
        end
    end

    // drive level codes go straight to the analog drivers
    assign reset_gate_drive = rg_cfg.drv;
    assign hclk_a_drive     = ha_cfg.drv;
    assign hclk_a_inv_drive = ha_inv_drv;
    assign hclk_b_drive     = hb_cfg.drv;
    assign hclk_b_inv_drive = hb_inv_drv;

    assign ref_loc = cfte_loc_decode(ref_loc_code);
    assign sig_loc = cfte_loc_decode(sig_loc_code);

    // one-step sample strobes; a hole code never fires
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reference_sample_strobe <= 1'b0;
            signal_sample_strobe    <= 1'b0;
        end else begin
            reference_sample_strobe <= ref_loc.valid && (pos == ref_loc.pos);
            signal_sample_strobe    <= sig_loc.valid && (pos == sig_loc.pos);
        end
    end

    // front-end control fields decoded from the two registers
    assign power_state_sel     = cfte_power_t'(operating_control[OPR_PWR_LSB +: 2]);
    assign black_clamp_en      = !operating_control[OPR_BLACK_BIT];
    assign test_bits           = operating_control[7:3];
    assign color_steer_mode    = cfte_steer_t'(color_steering_control[2:0]);
    assign pixel_gain_steer_en = color_steering_control[STEER_GAIN_BIT];

    // converter data: latched at the chosen position or passed every cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_data_out <= 10'h000;
        end else if (color_steering_control[STEER_LATCH_BIT] || pos == DOUT_LATCH_POS) begin
            adc_data_out <= adc_data_in;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            adc_data_oe_n <= 1'b0;
        end else begin
            adc_data_oe_n <= color_steering_control[STEER_FLOAT_BIT];
        end
    end

    // readback of settings and the live fine position
    always_comb begin
        next_rd_data = 8'h00;
        unique case (rd_addr)
            ADDR_OPR_LO:  next_rd_data = {2'b00, operating_control[5:0]};
            ADDR_OPR_HI:  next_rd_data = {6'h00, operating_control[7:6]};
            ADDR_STEER:   next_rd_data = {2'b00, color_steering_control};
            ADDR_RG_POL:  next_rd_data = {7'h00, rg_cfg.pol};
            ADDR_RG_RISE: next_rd_data = {2'b00, rg_cfg.rise};
            ADDR_RG_FALL: next_rd_data = {2'b00, rg_cfg.fall};
            ADDR_RG_DRV:  next_rd_data = {5'h00, rg_cfg.drv};
            ADDR_HA_POL:  next_rd_data = {7'h00, ha_cfg.pol};
            ADDR_HA_RISE: next_rd_data = {2'b00, ha_cfg.rise};
            ADDR_HA_FALL: next_rd_data = {2'b00, ha_cfg.fall};
            ADDR_HA_DRV:  next_rd_data = {5'h00, ha_cfg.drv};
            ADDR_HAI_DRV: next_rd_data = {5'h00, ha_inv_drv};
            ADDR_HB_POL:  next_rd_data = {7'h00, hb_cfg.pol};
            ADDR_HB_RISE: next_rd_data = {2'b00, hb_cfg.rise};
            ADDR_HB_FALL: next_rd_data = {2'b00, hb_cfg.fall};
            ADDR_HB_DRV:  next_rd_data = {5'h00, hb_cfg.drv};
            ADDR_HBI_DRV: next_rd_data = {5'h00, hb_inv_drv};
            ADDR_REF_LOC: next_rd_data = {2'b00, ref_loc_code};
            ADDR_SIG_LOC: next_rd_data = {2'b00, sig_loc_code};
            ADDR_STATUS:  next_rd_data = {2'b00, pos};
            default:      next_rd_data = 8'h00;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    a_inv_pair_a : assert property (@(posedge clk) disable iff (!rst_n)
        hclk_a_inv == !hclk_a) else $error("hclk_a_inv not inverse");
    a_inv_pair_b : assert property (@(posedge clk) disable iff (!rst_n)
        hclk_b_inv == !hclk_b) else $error("hclk_b_inv not inverse");
    a_ref_strobe : assert property (@(posedge clk) disable iff (!rst_n)
        (ref_loc.valid && pos == ref_loc.pos) |=> reference_sample_strobe ##1 !reference_sample_strobe)
        else $error("reference strobe misplaced");
    a_hole_silent : assert property (@(posedge clk) disable iff (!rst_n)
        !sig_loc.valid |=> !signal_sample_strobe) else $error("hole code fired strobe");
    a_opr_split : assert property (@(posedge clk) disable iff (!rst_n)
        wr_opr_hi |=> (operating_control[7:6] == $past(wr_data[1:0]))
        && (operating_control[5:0] == $past(operating_control[5:0])))
        else $error("operating control high load wrong");
    a_float_out : assert property (@(posedge clk) disable iff (!rst_n)
        color_steering_control[STEER_FLOAT_BIT] |=> adc_data_oe_n)
        else $error("converter outputs not floated");
    a_latch_hold : assert property (@(posedge clk) disable iff (!rst_n)
        (!color_steering_control[STEER_LATCH_BIT] && pos != DOUT_LATCH_POS)
        |=> $stable(adc_data_out)) else $error("latched data changed");

endmodule
`default_nettype wire

/* verification/cfte_far_model.sv */
// far-side model: master clock reference and converter data source
`timescale 1ns/1ps
`default_nettype none
module cfte_far_model (
    input  wire logic       clk,
    input  wire logic       align,
    output logic            master_clock_in,
    output logic [9:0]      adc_data_in
);
    // half-period counter of the reference, 24 fast cycles per half
    logic [4:0] half = 5'h00;
    // reference stands low until aligned, then runs free at 48 fast cycles
    initial master_clock_in = 1'b0;
    initial adc_data_in = 10'h000;
    // the only timing reference of the edge core; a one-cycle pulse would be
    // filtered by the synchroniser, so a real square wave is made
    always @(negedge clk) begin
        if (!align) begin
            half <= 5'h00;
        end else begin
            half <= (half == 5'h17) ? 5'h00 : half + 5'h01;
            if (half == 5'h00) master_clock_in <= ~master_clock_in;
        end
    end
    // word changes every cycle, so a stale output shows
    always @(negedge clk) adc_data_in <= adc_data_in + 10'h135;
endmodule
`default_nettype wire

/* verification/cfte_timing_gen_test.sv */
// self-checking bench for the fine-edge timing generator
`timescale 1ns/1ps
`default_nettype none
module cfte_timing_gen_test;
    import cfte_pkg::*;
    logic clk = 0, rst_n = 0, wr_en = 0, align = 0, pend = 0, mci;
    logic [7:0] wr_addr = 0, rd_addr = 0, rd_data;
    logic [5:0] wr_data = 0, d;
    logic [9:0] adi, ado, prev;
    logic rg, rg_oe, ha, ha_oe, hai, hb, hbi, rs, ss, blk, gain, a_oe, hai_oe, hb_oe, hbi_oe;
    logic [2:0] ha_drv, rg_drv, hb_drv;
    logic [4:0] tb_bits;
    cfte_power_t pwr;
    cfte_steer_t stm;
    logic [7:0] expq[$];
    int err_count = 0, n_checks = 0, cyc = 0, seed = 81144;
    logic [15:0] dflt[10] = '{16'h0000, 16'h0100, 16'h0600, 16'he720, 16'hee10,
                              16'hef02, 16'hf024, 16'hf420, 16'he903, 16'h5500};
    always #5 clk = ~clk;
    cfte_far_model cfte_far_model_inst (.clk(clk), .align(align), .master_clock_in(mci),
        .adc_data_in(adi));
    cfte_timing_gen cfte_timing_gen_inst (.clk(clk), .rst_n(rst_n), .master_clock_in(mci),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
        .rd_data(rd_data), .reset_gate_out(rg), .reset_gate_oe_n(rg_oe), .hclk_a(ha),
        .hclk_a_oe_n(ha_oe), .hclk_a_inv(hai), .hclk_a_inv_oe_n(hai_oe), .hclk_b(hb),
        .hclk_b_oe_n(hb_oe), .hclk_b_inv(hbi), .hclk_b_inv_oe_n(hbi_oe),
        .reset_gate_drive(rg_drv), .hclk_a_drive(ha_drv), .hclk_a_inv_drive(),
        .hclk_b_drive(hb_drv), .hclk_b_inv_drive(),
        .reference_sample_strobe(rs), .signal_sample_strobe(ss), .power_state_sel(pwr),
        .black_clamp_en(blk), .test_bits(tb_bits), .color_steer_mode(stm),
        .pixel_gain_steer_en(gain), .adc_data_in(adi), .adc_data_out(ado),
        .adc_data_oe_n(a_oe));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // extra edge at the end lets the register reach the outputs
    task automatic wr(input logic [7:0] a, input logic [5:0] v);
        @(negedge clk);
        wr_en = 1;
        wr_addr = a;
        wr_data = v;
        @(negedge clk);
        wr_en = 0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        rd_addr = a;
        pend = 1;
        expq.push_back(e);
        @(negedge clk);
        pend = 0;
    endtask
    // high counts over one whole period, independent of phase
    task automatic per(input int erg, input int eha, input int ehb, input int estb);
        int c[4];
        c = '{0, 0, 0, 0};
        repeat (60) @(negedge clk);
        repeat (48) begin
            @(negedge clk);
            c[0] += rg;
            c[1] += ha;
            c[2] += hb;
            c[3] += rs + ss;
            chk({hai, hbi}, {~ha, ~hb});
        end
        chk(16'(c[0]), 16'(erg));
        chk(16'(c[1]), 16'(eha));
        chk(16'(c[2]), 16'(ehb));
        chk(16'(c[3]), 16'(estb));
    endtask
    // read data lands just after the sampling edge
    always @(posedge clk) if (pend) #1 chk(rd_data, expq.pop_front());
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            wrap_up();
        end
    end
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1;
        @(negedge clk);
        align = 1;
        // rise, three synchroniser edges, then position 0 is read back
        @(posedge mci);
        repeat (3) @(negedge clk);
        rd(ADDR_STATUS, 8'h00);
        wr(8'h55, 6'h3f);
        foreach (dflt[i]) rd(dflt[i][15:8], dflt[i][7:0]);
        per(12, 24, 24, 2);
        wr(ADDR_HA_RISE, 6'h05);
        wr(ADDR_HA_FALL, 6'h21);
        wr(ADDR_HB_RISE, 6'h30);
        wr(ADDR_HB_FALL, 6'h3b);
        wr(ADDR_RG_RISE, 6'h0c);
        wr(ADDR_SIG_LOC, 6'h3c);
        per(0, 20, 11, 1);
        wr(ADDR_HA_POL, 6'h01);
        wr(ADDR_RG_POL, 6'h01);
        per(48, 28, 11, 1);
        wr(ADDR_HA_DRV, 6'h00);
        wr(ADDR_RG_DRV, 6'h00);
        chk({ha_oe, rg_oe, hai_oe, hb_oe, hbi_oe, ha_drv, rg_drv, hb_drv}, 16'h3003);
        wr(ADDR_HA_DRV, 6'h07);
        wr(ADDR_HAI_DRV, 6'h00);
        chk({ha_oe, hai_oe, ha_drv}, 16'hf);
        for (int m = 0; m < 8; m++) begin
            d = (6'($random(seed)) & 6'h28) | 6'({m[0], 1'b0, 3'(m)});
            wr(ADDR_STEER, d);
            rd(ADDR_STEER, 8'(d));
            chk({stm, gain, a_oe}, {3'(m), d[3], d[5]});
            @(posedge clk);
            prev = adi;
            @(negedge clk);
            if (d[4]) chk(16'(ado), 16'(prev));
        end
        for (int p = 0; p < 4; p++) begin
            d = (6'($random(seed)) & 6'h04) | 6'h10 | 6'(p);
            wr(ADDR_OPR_LO, d);
            wr(ADDR_OPR_HI, 6'h3c);
            rd(ADDR_OPR_LO, 8'(d));
            rd(ADDR_OPR_HI, 8'h00);
            chk({pwr, blk, tb_bits}, {2'(p), ~d[2], 5'b00010});
        end
        wrap_up();
    end
endmodule
`default_nettype wire
